// ---- hw/spl_pkg.sv ----
// Shared constants and carrier types for the serial-in parallel-out latch
package spl_pkg;

    // Register widths and depths
    localparam int SPL_WIDTH = 8;
    localparam int SPL_FIFO_DEPTH = 4;
    localparam int SPL_CNT_W = 3;

    // Stage positions
    localparam int SPL_FIRST_STAGE = 0;
    localparam int SPL_LAST_STAGE = 7;

    // Reset values
    localparam logic [7:0] SPL_SHIFT_RST = 8'h00;
    localparam logic [7:0] SPL_STORE_RST = 8'h00;
    localparam logic [7:0] SPL_CLEAR_VAL = 8'h00;
    localparam logic [7:0] SPL_PAR_IDLE = 8'h00;
    localparam logic SPL_CLK_PREV_RST = 1'b1;

    // Pin-side control inputs from the controller
    typedef struct packed {
        logic serial_data_in;
        logic shift_stage_clock;
        logic shift_clear_n;
        logic store_load_clock;
        logic out_enable_n;
    } spl_pins_in_t;

    // Pin-side outputs; oe bits are high while the device drives the pin
    typedef struct packed {
        logic [7:0] parallel_outputs;
        logic [7:0] parallel_outputs_oe;
        logic cascade_serial_out;
    } spl_pins_out_t;

    // Edge events found in one system clock
    typedef struct packed {
        logic shift_edge;
        logic load_edge;
    } spl_events_t;

endpackage

// ---- hw/spl_fifo.sv ----
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none

module spl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    // Honest full and empty flags
    assign in_ready_o = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push)
        begin
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
        if (push && !pop)
        begin
            count_nxt = count_r + 1'b1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Pointer registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage array, written on push only
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// ---- hw/spl_latch.sv ----
// Serial-in parallel-out latch: shift register, storage register, snapshot FIFO
//
// Operation
// - Eight shift stages feed an eight-bit storage register that drives the parallel outputs.
// - Both the shift clock and the load clock act only on rising edges.
// - With both clocks tied together the storage register trails the shift register by one.
// - Output enable high puts the parallel outputs in high impedance, low lets them drive.
// - The cascade output is always driven, whatever the output enable does.
// - Clear low forces every shift stage to zero; a load edge during clear loads zero into the storage register.
// - A shift edge with clear high takes the serial input into stage one and moves the rest up.
// - A load edge with clear high copies all eight shift stages into the storage register.
// - On coincident edges the storage register takes the contents from before the shift.
// - Register contents carry no meaning until the controller has initialised them.
`timescale 1ns/1ps
`default_nettype none

module spl_latch (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller-side pins
    input wire spl_pkg::spl_pins_in_t pins_i,
    // Device output pins
    output spl_pkg::spl_pins_out_t pins_o,
    // Stream of loaded storage words
    output logic snap_valid_o,
    input wire logic snap_ready_i,
    output logic [spl_pkg::SPL_WIDTH-1:0] snap_data_o,
    // Snapshot FIFO has room; a load while low drops its snapshot
    output logic snap_space_o,
    // Sticky flag: a snapshot was dropped for lack of room
    output logic snap_lost_o
);

    import spl_pkg::*;

    // Shift register and its next value
    logic [SPL_WIDTH-1:0] shift_r;
    logic [SPL_WIDTH-1:0] shift_nxt;
    // Storage register and its next value
    logic [SPL_WIDTH-1:0] store_r;
    logic [SPL_WIDTH-1:0] store_nxt;
    // Previous clock levels for edge detection
    logic sclk_prev_r;
    logic sclk_prev_nxt;
    logic lclk_prev_r;
    logic lclk_prev_nxt;
    // Registered pin drivers
    logic [SPL_WIDTH-1:0] par_r;
    logic [SPL_WIDTH-1:0] par_nxt;
    logic [SPL_WIDTH-1:0] par_oe_r;
    logic [SPL_WIDTH-1:0] par_oe_nxt;
    logic cascade_r;
    logic cascade_nxt;
    // Snapshot bookkeeping
    logic lost_r;
    logic lost_nxt;
    logic fifo_in_ready;
    // Per-stage shifted value
    logic [SPL_WIDTH-1:0] shifted;
    // Edge events of this cycle
    spl_events_t ev;

    // Rising edges only; falling edges and steady levels do nothing
    assign ev.shift_edge = pins_i.shift_stage_clock && !sclk_prev_r;
    assign ev.load_edge = pins_i.store_load_clock && !lclk_prev_r;

    // Clock level history
    always_comb
    begin
        sclk_prev_nxt = pins_i.shift_stage_clock;
        lclk_prev_nxt = pins_i.store_load_clock;
    end

    // Each stage takes the stage before it; stage one takes the serial input
    genvar gi;
    generate
        for (gi = 0; gi < SPL_WIDTH; gi++)
        begin : g_stage
            if (gi == SPL_FIRST_STAGE)
            begin : g_first
                assign shifted[gi] = pins_i.serial_data_in;
            end
            else
            begin : g_rest
                assign shifted[gi] = shift_r[gi-1];
            end
        end
    endgenerate

    // Shift register next value; clear overrides input and clocks
    always_comb
    begin
        shift_nxt = shift_r;
        if (!pins_i.shift_clear_n)
        begin
            shift_nxt = SPL_CLEAR_VAL;
        end
        else if (ev.shift_edge)
        begin
            shift_nxt = shifted;
        end
    end

    // Storage register samples the pre-shift contents on a load edge with clear high
    always_comb
    begin
        store_nxt = store_r;
        if (ev.load_edge)
        begin
            // Old shift_r is used even on a coincident shift edge
            if (pins_i.shift_clear_n)
            begin
                store_nxt = shift_r;
            end
            else
            begin
                store_nxt = SPL_CLEAR_VAL; // Clear wins over a same-cycle load
            end
        end
    end

    // Pin drivers; output enable only gates the drivers, never the contents
    always_comb
    begin
        cascade_nxt = shift_nxt[SPL_LAST_STAGE];
        if (pins_i.out_enable_n)
        begin
            par_oe_nxt = '0;
            par_nxt = SPL_PAR_IDLE;
        end
        else
        begin
            par_oe_nxt = '1;
            par_nxt = store_nxt;
        end
    end

    // Snapshot loss flag: set by a load that finds the FIFO full
    always_comb
    begin
        lost_nxt = lost_r;
        if (ev.load_edge && !fifo_in_ready)
        begin
            lost_nxt = 1'b1;
        end
    end

    // Edge history registers; start high so a high clock at release is no edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sclk_prev_r <= SPL_CLK_PREV_RST;
            lclk_prev_r <= SPL_CLK_PREV_RST;
        end
        else
        begin
            sclk_prev_r <= sclk_prev_nxt;
            lclk_prev_r <= lclk_prev_nxt;
        end
    end

    // Shift and storage registers; reset gives a known start for simulation
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shift_r <= SPL_SHIFT_RST;
            store_r <= SPL_STORE_RST;
        end
        else
        begin
            shift_r <= shift_nxt;
            store_r <= store_nxt;
        end
    end

    // Pin driver registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            par_r <= SPL_PAR_IDLE;
            par_oe_r <= '0;
            cascade_r <= 1'b0;
            lost_r <= 1'b0;
        end
        else
        begin
            par_r <= par_nxt;
            par_oe_r <= par_oe_nxt;
            cascade_r <= cascade_nxt;
            lost_r <= lost_nxt;
        end
    end

    // Output pins; cascade has no enable and is always driven
    assign pins_o.parallel_outputs = par_r;
    assign pins_o.parallel_outputs_oe = par_oe_r;
    assign pins_o.cascade_serial_out = cascade_r;
    assign snap_lost_o = lost_r;
    assign snap_space_o = fifo_in_ready;

    // Each loaded storage word is queued for the user side while the FIFO has room
    spl_fifo #(
        .WIDTH(SPL_WIDTH),
        .DEPTH(SPL_FIFO_DEPTH)
    ) u_snap_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(ev.load_edge),
        .in_ready_o(fifo_in_ready),
        .in_data_i(store_nxt),
        .out_valid_o(snap_valid_o),
        .out_ready_i(snap_ready_i),
        .out_data_o(snap_data_o)
    );

endmodule

`default_nettype wire

// ---- tb/spl_ctl_model.sv ----
// Controller model that drives the latch pins from the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module spl_ctl_model (
    // Clock
    input wire logic clk_i,
    // Pins toward the latch
    output spl_pkg::spl_pins_in_t pins_o
);
    import spl_pkg::*;

    // Idle: clocks low, clear off, outputs off
    initial
    begin
        pins_o = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    end

    // One pulse on the chosen clocks; data leaves its level once hold is over
    task automatic pulse(input logic s, input logic l, input logic d);
    begin
        pins_o.serial_data_in = d;
        @(negedge clk_i);
        pins_o.shift_stage_clock = s;
        pins_o.store_load_clock = l;
        @(negedge clk_i);
        pins_o.shift_stage_clock = 1'b0;
        pins_o.store_load_clock = 1'b0;
        pins_o.serial_data_in = ~d;
        @(negedge clk_i);
    end
    endtask

    // Clear held over two samples
    task automatic clear();
    begin
        pins_o.shift_clear_n = 1'b0;
        repeat (2) @(negedge clk_i);
        pins_o.shift_clear_n = 1'b1;
        @(negedge clk_i);
    end
    endtask

    // Output enable change, settled on return
    task automatic set_oe(input logic v);
    begin
        pins_o.out_enable_n = v;
        repeat (2) @(negedge clk_i);
    end
    endtask

    // Start-up: outputs off, clear, then load the cleared stages
    task automatic init();
    begin
        set_oe(1'b1);
        clear();
        pulse(1'b0, 1'b1, 1'b0);
    end
    endtask
endmodule

`default_nettype wire

// ---- tb/spl_latch_assertions.sv ----
// Concurrent checks on the latch pins and snapshot stream
`timescale 1ns/1ps
`default_nettype none

module spl_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire spl_pkg::spl_pins_in_t pins_i,
    input wire spl_pkg::spl_pins_out_t pins_o,
    input wire logic snap_valid_o,
    input wire logic snap_ready_i,
    input wire logic [7:0] snap_data_o,
    input wire logic snap_space_o,
    input wire logic snap_lost_o
);
    import spl_pkg::*;

    // Short names for watched pins
    wire logic sclk = pins_i.shift_stage_clock;
    wire logic lclk = pins_i.store_load_clock;
    wire logic clr_n = pins_i.shift_clear_n;
    wire logic oen = pins_i.out_enable_n;
    wire logic casc = pins_o.cascade_serial_out;
    wire logic [7:0] par = pins_o.parallel_outputs;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Output enable and disabled level
    oe_off_a: assert property (oen |=> pins_o.parallel_outputs_oe == 8'h00)
        else $error("parallel outputs driven while disabled");
    oe_on_a: assert property (!oen |=> pins_o.parallel_outputs_oe == 8'hff)
        else $error("parallel outputs not driven while enabled");
    dis_zero_a: assert property (oen |=> par == 8'h00)
        else $error("disabled outputs not at idle level");
    // Clear and clock edges on the shift stages and the storage register
    clear_casc_a: assert property (!clr_n |-> ##2 !casc)
        else $error("cascade output not cleared");
    // Cascade register follows the stage next value, so a held stage shows one edge later
    hold_shift_a: assert property (!$rose(sclk) && clr_n |=> $stable(casc))
        else $error("shift stages moved without a rising shift edge");
    load_copy_a: assert property (
        $rose(lclk) && clr_n && !$past(rst_i) ##1 !oen |=> par[7] == $past(casc, 2))
        else $error("storage did not take the last shift stage");
    clear_store_a: assert property (
        !oen ##1 (!clr_n && !$rose(lclk) && !oen) |=> $stable(par))
        else $error("storage changed by the shift clear");
    // Snapshot pushes and drops
    snap_push_a: assert property (
        $rose(lclk) && snap_space_o && !$past(rst_i) |=> snap_valid_o)
        else $error("load edge did not queue a snapshot");
    snap_lost_a: assert property (
        $rose(lclk) && !snap_space_o && !snap_ready_i && !$past(rst_i) |=> snap_lost_o)
        else $error("dropped snapshot not flagged");

    // Main scenarios reached
    cov_tied_c: cover property ($rose(sclk) && $rose(lclk));
    cov_full_c: cover property (!snap_space_o);
    cov_clear_c: cover property (!clr_n && !oen);
endmodule

bind spl_latch spl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .pins_o(pins_o),
    .snap_valid_o(snap_valid_o), .snap_ready_i(snap_ready_i), .snap_data_o(snap_data_o),
    .snap_space_o(snap_space_o), .snap_lost_o(snap_lost_o));

`default_nettype wire

// ---- tb/spl_testbench.sv ----
// Self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) chk(n, e, a)

module testbench;
    import spl_pkg::*;

    // Bench state
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic snap_ready_i = 1'b1;
    logic snap_valid_o, snap_space_o, snap_lost_o, en;
    logic [7:0] snap_data_o, sh, st;
    logic [7:0] q[$];
    wire logic [7:0] par_w;
    spl_pins_in_t pins_i;
    spl_pins_out_t pins_o;
    int n_errors = 0;
    int checks = 0;

    // Clock, controller and device
    always #4 clk_i = ~clk_i;
    spl_ctl_model ctl (.clk_i(clk_i), .pins_o(pins_i));
    spl_latch dut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_i), .pins_o(pins_o),
        .snap_valid_o(snap_valid_o), .snap_ready_i(snap_ready_i), .snap_data_o(snap_data_o),
        .snap_space_o(snap_space_o), .snap_lost_o(snap_lost_o));

    // Parallel pins as the board sees them
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        assign par_w[i] = pins_o.parallel_outputs_oe[i] ? pins_o.parallel_outputs[i] : 1'bz;
    end

    // One comparison
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] a);
    begin
        checks++;
        if (e !== a)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, a);
            n_errors++;
        end
    end
    endtask

    // Pins against the shadow registers
    task automatic look();
    begin
        `CHK("cascade", sh[7], pins_o.cascade_serial_out);
        `CHK("parallel", en ? st : 8'hzz, par_w);
    end
    endtask

    // Clock pulse with shadow update; load sees the stages before the shift
    task automatic step(input logic s, input logic l, input logic d);
    begin
        ctl.pulse(s, l, d);
        if (l)
            st = sh;
        if (s)
            sh = {sh[6:0], d};
        look();
    end
    endtask

    // Start-up with outputs off, then enable them
    task automatic t_init();
    begin
        en = 1'b0;
        sh = 8'h00;
        st = 8'h00;
        ctl.init();
        look();
        ctl.set_oe(1'b0);
        en = 1'b1;
        look();
        $display("test init done");
    end
    endtask

    // Shift a byte in, then load it and toggle the enable
    task automatic t_shift();
        logic [7:0] d = 8'ha5;
    begin
        for (int i = 7; i >= 0; i--)
            step(1'b1, 1'b0, d[i]);
        step(1'b0, 1'b1, 1'b0);
        `CHK("loaded", 8'ha5, par_w);
        ctl.set_oe(1'b1);
        en = 1'b0;
        look();
        ctl.set_oe(1'b0);
        en = 1'b1;
        look();
        $display("test shift done");
    end
    endtask

    // Both clocks tied, then a clear
    task automatic t_tied();
        logic [7:0] d = 8'h3c;
    begin
        for (int i = 7; i >= 0; i--)
            step(1'b1, 1'b1, d[i]);
        `CHK("trail", 8'h9e, par_w);
        ctl.clear();
        sh = 8'h00;
        look();
        step(1'b1, 1'b0, 1'b1);
        $display("test tied done");
    end
    endtask

    // Snapshot queue filled past full while stalled, then drained
    task automatic t_fifo();
    begin
        snap_ready_i = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            step(1'b1, 1'b1, i[0]);
            if (i < 4)
                q.push_back(st);
        end
        `CHK("space", 1'b0, snap_space_o);
        `CHK("lost", 1'b1, snap_lost_o);
        foreach (q[i])
        begin
            `CHK("valid", 1'b1, snap_valid_o);
            `CHK("word", q[i], snap_data_o);
            snap_ready_i = 1'b1;
            @(negedge clk_i);
            snap_ready_i = 1'b0;
        end
        `CHK("empty", 1'b0, snap_valid_o);
        $display("test fifo done");
    end
    endtask

    // Verdict
    task automatic results();
    begin
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_init();
        t_shift();
        t_tied();
        t_fifo();
        results();
    end

    // Hang guard
    initial
    begin
        #100000;
        n_errors++;
        results();
    end
endmodule

`default_nettype wire
